// ===== logic/ssv_pkg.sv
// Package: constants and types for the supervised serial EEPROM slave
package ssv_pkg;
   localparam int         CLK_HZ       = 40_000_000;
   localparam int         CLK_NS       = 25;
   localparam int         PURST_MS     = 200;
   localparam int         TWC_MS       = 5;
   localparam int         MAN_GLITCH_NS = 100;
   localparam int         PURST_CYC    = PURST_MS * (CLK_HZ / 1000);
   localparam int         TWC_CYC      = TWC_MS * (CLK_HZ / 1000);
   // Longest time, so round down, but never below one cycle
   localparam int         MAN_FILT_CYC = (MAN_GLITCH_NS / CLK_NS < 1) ? 1
                                        : MAN_GLITCH_NS / CLK_NS;
   localparam logic [3:0] TYPE_CODE    = 4'hA;
   localparam int         MEM_BYTES    = 256;
   localparam int         PAGE_BYTES   = 16;
   localparam logic [2:0] BIT_LAST     = 3'h7;

   typedef enum logic [1:0] {K_ADDR, K_WADDR, K_DATA} ssv_kind_t;
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_WAIT} ssv_state_t;
endpackage

// ===== logic/ssv_sup_if.sv
// Interface: supervisor reset state handed to the bus slave core
`timescale 1ns/1ps
interface ssv_sup_if;
   logic rst_act;
   modport sup  (output rst_act);
   modport core (input  rst_act);
endinterface

// ===== logic/ssv_supervisor.sv
// Supervisor: threshold, manual and pin reset sources with timeout stretch
`timescale 1ns/1ps
module ssv_supervisor #(
   parameter int P_PURST_CYC = ssv_pkg::PURST_CYC
) (
   input  logic      i_clk,
   input  logic      i_rst,
   input  logic      i_below_thr,
   input  logic      i_manual_push_reset_n,
   input  logic      i_rst_pin_n,
   ssv_sup_if.sup    sup
);
   localparam int         TW   = $clog2(P_PURST_CYC + 1);
   localparam int         FILT = ssv_pkg::MAN_FILT_CYC;
   localparam int         FW   = $clog2(FILT + 1);
   localparam logic [TW-1:0] RELOAD = TW'(P_PURST_CYC);
   localparam logic [FW-1:0] FILT_V = FW'(FILT);

   if (P_PURST_CYC < 2) begin : g_chk
      $error("P_PURST_CYC must be at least 2");
   end

   logic [1:0]    bt_sy_ff, man_sy_ff, pin_sy_ff;
   logic          pin_d_ff;
   logic [FW-1:0] man_cnt_ff;
   logic [TW-1:0] tmo_ff;
   logic          rst_act_ff;
   logic          man_act, pin_fall, trig;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         bt_sy_ff  <= 2'h0;
         man_sy_ff <= 2'h3;
         pin_sy_ff <= 2'h3;
         pin_d_ff  <= 1'b1;
      end else begin
         bt_sy_ff  <= {bt_sy_ff[0], i_below_thr};
         man_sy_ff <= {man_sy_ff[0], i_manual_push_reset_n};
         pin_sy_ff <= {pin_sy_ff[0], i_rst_pin_n};
         pin_d_ff  <= pin_sy_ff[1];
      end
   end

   // Low must persist past the glitch window before it counts
   always_ff @(posedge i_clk) begin
      if (i_rst || man_sy_ff[1]) begin
         man_cnt_ff <= '0;
      end else if (man_cnt_ff != FILT_V) begin
         man_cnt_ff <= man_cnt_ff + FW'(1);
      end
   end

   assign man_act  = (man_cnt_ff == FILT_V);
   // Our own drive of the pin must not retrigger the timeout
   assign pin_fall = pin_d_ff & ~pin_sy_ff[1] & ~rst_act_ff;
   assign trig     = bt_sy_ff[1] | man_act | pin_fall;

   always_ff @(posedge i_clk) begin
      if (i_rst || trig) begin
         tmo_ff <= RELOAD;
      end else if (tmo_ff != '0) begin
         tmo_ff <= tmo_ff - TW'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rst_act_ff <= 1'b1;
      end else begin
         rst_act_ff <= trig | (tmo_ff != '0);
      end
   end

   assign sup.rst_act = rst_act_ff;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sup_brown_a: assert property (bt_sy_ff[1] |=> rst_act_ff)
      else $error("reset not asserted below threshold");
   sup_pin_hold_a: assert property (pin_fall |=> rst_act_ff [*2])
      else $error("pin falling edge did not start a timeout");
   sup_man_filt_a: assert property ($rose(man_act) |-> !$past(man_sy_ff[1], FILT))
      else $error("manual reset accepted before glitch window");
   sup_timeout_a: assert property ($fell(rst_act_ff) |-> $past(tmo_ff, 2) == TW'(1))
      else $error("reset released before timeout ran out");
   sup_man_cv: cover property (man_act ##1 !man_act ##[1:300] !rst_act_ff);
endmodule

// ===== logic/ssv_eeprom_slave.sv
// Top: two-wire EEPROM slave with page buffer, gated by the supervisor
`timescale 1ns/1ps
// Function
// - Hold reset outputs for timeout after power-up
// - Below threshold asserts reset at once
// - Reset pin falling edge restarts timeout
// - Short external reset still gives full timeout
// - Manual reset held low, plus one timeout
// - Manual reset pulses under 100 ns ignored
// - Reset aborts and refuses all bus traffic
// - Reset blocks new programming, running one finishes
// - Write-protect high inhibits every array write; a programming cycle already running still writes
// - Start is SDA fall with SCL high
// - Stop is SDA rise with SCL high
// - Upper address nibble compared with type code
// - Address LSB selects read or write
// - Matching address is acknowledged, then served
// - Receiver pulls SDA low on ninth clock
// - Written data bytes acknowledged unless write-protect is high
// - Read continues on master ack, else waits
// - Byte write programs at the stop
// - Page write increments low address bits only
// - Over sixteen bytes wrap and overwrite buffer
// - No address ack while programming runs
// - Programming completes within five milliseconds
// - Power-up timeout inside 130 to 270 ms
module ssv_eeprom_slave #(
   parameter int P_PURST_CYC = ssv_pkg::PURST_CYC,
   parameter int P_TWC_CYC   = ssv_pkg::TWC_CYC
) (
   input  logic i_clk,
   input  logic i_rst,
   input  logic i_scl,
   input  logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   input  logic i_below_thr,
   input  logic i_manual_push_reset_n,
   input  logic i_rst_pin_n,
   output logic o_rst_pin,
   output logic o_rst_pin_oe_n,
   output logic o_reset,
   input  logic i_wp
);
   localparam int PW = $clog2(P_TWC_CYC);

   if (P_TWC_CYC < 2) begin : g_chk
      $error("P_TWC_CYC must be at least 2");
   end

   ssv_sup_if sif ();

   ssv_supervisor #(.P_PURST_CYC(P_PURST_CYC)) u_sup (
      .i_clk                 (i_clk),
      .i_rst                 (i_rst),
      .i_below_thr           (i_below_thr),
      .i_manual_push_reset_n (i_manual_push_reset_n),
      .i_rst_pin_n           (i_rst_pin_n),
      .sup                   (sif)
   );

   logic [1:0]             scl_sy_ff, sda_sy_ff, wp_sy_ff;
   logic                   scl_d_ff, sda_d_ff;
   ssv_pkg::ssv_state_t    st_ff;
   ssv_pkg::ssv_kind_t     kind_ff;
   logic [2:0]             cnt_ff;
   logic                   done_ff, rd_ff, mack_ff;
   logic [7:0]             sh_ff, tx_ff, ptr_ff;
   logic                   sda_oe_n_ff, zero_ff, rst_out_ff, rst_oe_n_ff;
   logic [7:0]             mem_ff [ssv_pkg::MEM_BYTES];
   logic [7:0]             pg_ff  [ssv_pkg::PAGE_BYTES];
   logic [ssv_pkg::PAGE_BYTES-1:0] vld_ff;
   logic                   prog_ff;
   logic [PW-1:0]          prog_cnt_ff;
   logic [3:0]             pgsel_ff;
   logic                   scl_h, scl_rise, scl_fall, start, stop;
   logic                   addr_hit, go_ack, acc_data, set_ptr, ld_tx;
   logic                   commit, prog_end;

   // Bus pins come from another domain; two stages before any use
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         scl_sy_ff <= 2'h3;
         sda_sy_ff <= 2'h3;
         wp_sy_ff  <= 2'h0;
         scl_d_ff  <= 1'b1;
         sda_d_ff  <= 1'b1;
      end else begin
         scl_sy_ff <= {scl_sy_ff[0], i_scl};
         sda_sy_ff <= {sda_sy_ff[0], i_sda};
         wp_sy_ff  <= {wp_sy_ff[0], i_wp};
         scl_d_ff  <= scl_sy_ff[1];
         sda_d_ff  <= sda_sy_ff[1];
      end
   end

   assign scl_h    = scl_sy_ff[1] & scl_d_ff;
   assign scl_rise = scl_sy_ff[1] & ~scl_d_ff;
   assign scl_fall = ~scl_sy_ff[1] & scl_d_ff;
   assign start    = scl_h & sda_d_ff & ~sda_sy_ff[1];
   assign stop     = scl_h & ~sda_d_ff & sda_sy_ff[1];

   // Decision taken at the falling edge that ends the eighth bit
   always_comb begin
      addr_hit = (sh_ff[7:4] == ssv_pkg::TYPE_CODE) && !prog_ff;
      go_ack   = 1'b0;
      acc_data = 1'b0;
      set_ptr  = 1'b0;
      if (st_ff == ssv_pkg::ST_RX && done_ff && scl_fall && !sif.rst_act) begin
         case (kind_ff)
            ssv_pkg::K_ADDR: begin
               go_ack = addr_hit;
            end
            ssv_pkg::K_WADDR: begin
               go_ack  = 1'b1;
               set_ptr = 1'b1;
            end
            default: begin
               go_ack   = !wp_sy_ff[1];
               acc_data = !wp_sy_ff[1];
            end
         endcase
      end
   end

   assign ld_tx = scl_fall && !sif.rst_act && !start && !stop
                  && ((st_ff == ssv_pkg::ST_ACK && kind_ff == ssv_pkg::K_ADDR && rd_ff)
                      || (st_ff == ssv_pkg::ST_MACK && mack_ff));

   // Byte protocol engine
   always_ff @(posedge i_clk) begin
      if (i_rst || sif.rst_act) begin
         st_ff       <= ssv_pkg::ST_IDLE;
         kind_ff     <= ssv_pkg::K_ADDR;
         cnt_ff      <= 3'h0;
         done_ff     <= 1'b0;
         rd_ff       <= 1'b0;
         mack_ff     <= 1'b0;
         sh_ff       <= 8'h00;
         tx_ff       <= 8'h00;
         sda_oe_n_ff <= 1'b1;
      end else if (start) begin
         st_ff       <= ssv_pkg::ST_RX;
         kind_ff     <= ssv_pkg::K_ADDR;
         cnt_ff      <= 3'h0;
         done_ff     <= 1'b0;
         sda_oe_n_ff <= 1'b1;
      end else if (stop) begin
         st_ff       <= ssv_pkg::ST_IDLE;
         sda_oe_n_ff <= 1'b1;
      end else begin
         case (st_ff)
            ssv_pkg::ST_RX: begin
               if (scl_rise) begin
                  sh_ff   <= {sh_ff[6:0], sda_sy_ff[1]};
                  cnt_ff  <= cnt_ff + 3'h1;
                  done_ff <= (cnt_ff == ssv_pkg::BIT_LAST);
               end else if (scl_fall && done_ff) begin
                  done_ff <= 1'b0;
                  if (go_ack) begin
                     st_ff       <= ssv_pkg::ST_ACK;
                     sda_oe_n_ff <= 1'b0;
                     if (kind_ff == ssv_pkg::K_ADDR) begin
                        rd_ff <= sh_ff[0];
                     end
                  end else begin
                     st_ff <= ssv_pkg::ST_WAIT;
                  end
               end
            end
            ssv_pkg::ST_ACK: begin
               if (scl_fall) begin
                  cnt_ff <= 3'h0;
                  if (ld_tx) begin
                     st_ff       <= ssv_pkg::ST_TX;
                     tx_ff       <= mem_ff[ptr_ff];
                     sda_oe_n_ff <= mem_ff[ptr_ff][7];
                  end else begin
                     st_ff       <= ssv_pkg::ST_RX;
                     sda_oe_n_ff <= 1'b1;
                     kind_ff     <= (kind_ff == ssv_pkg::K_ADDR) ? ssv_pkg::K_WADDR
                                                                 : ssv_pkg::K_DATA;
                  end
               end
            end
            ssv_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (cnt_ff == ssv_pkg::BIT_LAST) begin
                     st_ff       <= ssv_pkg::ST_MACK;
                     sda_oe_n_ff <= 1'b1;
                  end else begin
                     tx_ff       <= {tx_ff[6:0], 1'b0};
                     sda_oe_n_ff <= tx_ff[6];
                     cnt_ff      <= cnt_ff + 3'h1;
                  end
               end
            end
            ssv_pkg::ST_MACK: begin
               if (scl_rise) begin
                  mack_ff <= !sda_sy_ff[1];
               end else if (scl_fall) begin
                  cnt_ff <= 3'h0;
                  if (ld_tx) begin
                     st_ff       <= ssv_pkg::ST_TX;
                     tx_ff       <= mem_ff[ptr_ff];
                     sda_oe_n_ff <= mem_ff[ptr_ff][7];
                  end else begin
                     st_ff <= ssv_pkg::ST_WAIT;
                  end
               end
            end
            ssv_pkg::ST_WAIT: begin
               sda_oe_n_ff <= 1'b1;
            end
            default: begin
               st_ff <= ssv_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Writes roll the low nibble only; reads step through the whole array
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ptr_ff <= 8'h00;
      end else if (set_ptr) begin
         ptr_ff <= sh_ff;
      end else if (acc_data) begin
         ptr_ff <= {ptr_ff[7:4], ptr_ff[3:0] + 4'h1};
      end else if (ld_tx) begin
         ptr_ff <= ptr_ff + 8'h01;
      end
   end

   // Page buffer; the buffer is frozen while programming since addresses are refused
   always_ff @(posedge i_clk) begin
      if (acc_data) begin
         pg_ff[ptr_ff[3:0]] <= sh_ff;
      end
   end

   assign commit   = stop && (|vld_ff) && !prog_ff && !sif.rst_act
                     && !wp_sy_ff[1];
   assign prog_end = prog_ff && (prog_cnt_ff == '0);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         vld_ff <= '0;
      end else if (prog_end || (!prog_ff && (sif.rst_act || (stop && !commit)))) begin
         vld_ff <= '0;
      end else if (acc_data) begin
         vld_ff[ptr_ff[3:0]] <= 1'b1;
      end
   end

   // Supervisor reset is not looked at here: a started cycle runs to its end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         prog_ff     <= 1'b0;
         prog_cnt_ff <= '0;
         pgsel_ff    <= 4'h0;
      end else if (commit) begin
         prog_ff     <= 1'b1;
         prog_cnt_ff <= PW'(P_TWC_CYC - 1);
         pgsel_ff    <= ptr_ff[7:4];
      end else if (prog_ff) begin
         if (prog_end) begin
            prog_ff <= 1'b0;
         end else begin
            prog_cnt_ff <= prog_cnt_ff - PW'(1);
         end
      end
   end

   // Array contents are not reset, like the nonvolatile cells they stand for
   always_ff @(posedge i_clk) begin
      if (prog_end) begin
         for (int i = 0; i < ssv_pkg::PAGE_BYTES; i++) begin
            if (vld_ff[i]) begin
               mem_ff[{pgsel_ff, 4'(i)}] <= pg_ff[i];
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         zero_ff     <= 1'b0;
         rst_out_ff  <= 1'b1;
         rst_oe_n_ff <= 1'b0;
      end else begin
         zero_ff     <= 1'b0;
         rst_out_ff  <= sif.rst_act;
         rst_oe_n_ff <= !sif.rst_act;
      end
   end

   assign o_sda          = zero_ff;
   assign o_sda_oe_n     = sda_oe_n_ff;
   assign o_rst_pin      = zero_ff;
   assign o_rst_pin_oe_n = rst_oe_n_ff;
   assign o_reset        = rst_out_ff;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   abort_idle_a: assert property (sif.rst_act |=> st_ff == ssv_pkg::ST_IDLE && o_sda_oe_n)
      else $error("bus traffic not aborted under reset");
   busy_nack_a: assert property (prog_ff && st_ff == ssv_pkg::ST_RX
                                 && kind_ff == ssv_pkg::K_ADDR
                                 && done_ff && scl_fall |=> st_ff != ssv_pkg::ST_ACK)
      else $error("address acknowledged while programming");
   ack_drive_a: assert property (st_ff == ssv_pkg::ST_ACK |-> !o_sda_oe_n)
      else $error("acknowledge slot not driven low");
   prog_start_a: assert property (commit |=> prog_ff ##1 prog_ff)
      else $error("programming did not start at stop");
   prog_gate_a: assert property ($rose(prog_ff) |-> !$past(wp_sy_ff[1]) && !$past(sif.rst_act))
      else $error("programming started under protect or reset");
   prog_len_a: assert property (prog_ff && prog_cnt_ff == PW'(1) |=> prog_ff ##1 !prog_ff)
      else $error("programming cycle length wrong");
   page_wrap_a: assert property (acc_data |=> ptr_ff[7:4] == $past(ptr_ff[7:4])
                                 && ptr_ff[3:0] == $past(ptr_ff[3:0]) + 4'h1)
      else $error("page write address step wrong");
   rd_nack_a: assert property (st_ff == ssv_pkg::ST_MACK && !mack_ff
                               && scl_fall && !start && !stop && !sif.rst_act
                               |=> st_ff == ssv_pkg::ST_WAIT && o_sda_oe_n)
      else $error("read went on without master acknowledge");
   byte_wr_cv: cover property (commit ##1 prog_ff);
   read_cv: cover property (st_ff == ssv_pkg::ST_TX ##[1:400] st_ff == ssv_pkg::ST_MACK);
   poll_cv: cover property (prog_ff && st_ff == ssv_pkg::ST_RX ##1 st_ff == ssv_pkg::ST_WAIT);
endmodule

// ===== tb/ssv_bus_master.sv
// Partner model: two-wire bus master that makes the link clock and data
`timescale 1ns/1ps
module ssv_bus_master (
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   localparam int Q = 50;

   // Clock stands high between frames, data released to the pull-up
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   // Serves as repeated start too; odd lead-in keeps the phase drifting.
   // The slave lets go of its ack a few system clocks after SCL falls,
   // so SCL must not rise before then or a false stop is seen.
   task automatic start();
      #(Q + 7);
      o_sda = 1'b1;
      #(Q);
      o_scl = 1'b1;
      #(2 * Q);
      o_sda = 1'b0;
      #(2 * Q);
      o_scl = 1'b0;
   endtask

   task automatic stop();
      #(Q);
      o_sda = 1'b0;
      #(Q);
      o_scl = 1'b1;
      #(2 * Q);
      o_sda = 1'b1;
      #(2 * Q);
   endtask

   // Data moves only mid-low, so it never changes with the clock high
   task automatic bit_io(input logic d, output logic q);
      #(Q);
      o_sda = d;
      #(Q);
      o_scl = 1'b1;
      #(Q);
      q = i_sda;
      #(Q);
      o_scl = 1'b0;
   endtask

   task automatic wr(input logic [7:0] b, output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], q);
      bit_io(1'b1, q);
      ack = ~q;
   endtask

   task automatic rd(input logic ack, output logic [7:0] b);
      logic q;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, b[i]);
      bit_io(~ack, q);
   endtask
endmodule

// ===== tb/ssv_eeprom_slave_tb_top.sv
// Testbench: supervised two-wire EEPROM slave against a bus master model
`timescale 1ns/1ps
module ssv_eeprom_slave_tb_top;
   localparam int PURST = 200;
   localparam int TWC   = 100;
   logic       i_clk               = 1'b0;
   logic       i_rst               = 1'b1;
   logic       i_below_thr         = 1'b0;
   logic       manual_push_reset_n = 1'b1;
   logic       pin_drv_n           = 1'b1;
   logic       i_wp                = 1'b0;
   wire logic  scl;
   wire logic  sda_m;
   logic       o_sda;
   logic       o_sda_oe_n;
   logic       o_rst_pin;
   logic       o_rst_pin_oe_n;
   logic       o_reset;
   wire logic  sda       = sda_m & (o_sda_oe_n | o_sda);
   wire logic  rst_pin_n = pin_drv_n & (o_rst_pin_oe_n | o_rst_pin);
   int         bad_count = 0;
   int         checks    = 0;
   logic [7:0] img [256];

   always #(12.5) i_clk = ~i_clk;

   ssv_bus_master m (
      .i_sda (sda),
      .o_scl (scl),
      .o_sda (sda_m)
   );

   ssv_eeprom_slave #(.P_PURST_CYC(PURST), .P_TWC_CYC(TWC)) dut (
      .i_clk                 (i_clk),
      .i_rst                 (i_rst),
      .i_scl                 (scl),
      .i_sda                 (sda),
      .o_sda                 (o_sda),
      .o_sda_oe_n            (o_sda_oe_n),
      .i_below_thr           (i_below_thr),
      .i_manual_push_reset_n (manual_push_reset_n),
      .i_rst_pin_n           (rst_pin_n),
      .o_rst_pin             (o_rst_pin),
      .o_rst_pin_oe_n        (o_rst_pin_oe_n),
      .o_reset               (o_reset),
      .i_wp                  (i_wp)
   );

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      checks++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   // Counts cycles until the reset output reaches lvl; a spent bound ends the run
   task automatic wait_rst(input logic lvl, input int bound, output int n);
      n = 0;
      while (o_reset !== lvl) begin
         @(negedge i_clk);
         n++;
         if (n > bound) begin
            bad_count++;
            $display("unexpected reset wait: expected %b seen %b", lvl, o_reset);
            final_report();
         end
      end
      chk("pin drive enable", {7'h00, ~lvl}, {7'h00, o_rst_pin_oe_n});
      chk("reset pin level", {7'h00, ~lvl}, {7'h00, rst_pin_n});
   endtask

   task automatic send(input string what, input logic [7:0] b, input logic exp_ack);
      logic a;
      m.wr(b, a);
      chk(what, {7'h00, exp_ack}, {7'h00, a});
   endtask

   task automatic write_bytes(input logic [7:0] addr, input logic [7:0] d0, input int n,
                              input logic ok);
      m.start();
      send("address ack", 8'hA0, 1'b1);
      send("word ack", addr, 1'b1);
      for (int i = 0; i < n; i++) begin
         send("data ack", d0 + 8'(i), ok);
         if (ok)
            img[{addr[7:4], 4'(addr[3:0] + i)}] = d0 + 8'(i);
      end
      m.stop();
   endtask

   task automatic read_chk(input logic [7:0] addr, input int n);
      logic [7:0] d;
      m.start();
      send("address ack", 8'hA0, 1'b1);
      send("word ack", addr, 1'b1);
      m.start();
      send("read address ack", 8'hA1, 1'b1);
      for (int i = 0; i < n; i++) begin
         m.rd(i < n - 1, d);
         chk("read data", img[8'(addr + i)], d);
      end
      m.stop();
   endtask

   task automatic poll(input logic exp_ack);
      m.start();
      send("poll ack", 8'hA0, exp_ack);
      m.stop();
   endtask

   task automatic t_write_poll();
      write_bytes(8'h10, 8'h5A, 1, 1'b1);
      poll(1'b0);
      poll(1'b1);
      read_chk(8'h10, 1);
   endtask

   task automatic t_type_code();
      logic [7:0] bad [4] = '{8'h50, 8'hB0, 8'h20, 8'hE0};
      foreach (bad[i]) begin
         m.start();
         send("foreign address", bad[i], 1'b0);
         m.stop();
      end
   endtask

   // Protected write must leave the array and the busy state untouched
   task automatic t_protect();
      @(negedge i_clk);
      i_wp = 1'b1;
      write_bytes(8'h10, 8'h33, 1, 1'b0);
      @(negedge i_clk);
      i_wp = 1'b0;
      poll(1'b1);
      read_chk(8'h10, 1);
   endtask

   task automatic t_page();
      write_bytes(8'h2E, 8'h80, 18, 1'b1);
      poll(1'b0);
      poll(1'b1);
      read_chk(8'h20, 16);
   endtask

   task automatic t_manual();
      int n;
      logic seen = 1'b0;
      @(negedge i_clk);
      manual_push_reset_n = 1'b0;
      repeat (2) @(negedge i_clk);
      manual_push_reset_n = 1'b1;
      repeat (12) begin
         @(negedge i_clk);
         seen = seen | o_reset;
      end
      chk("glitch reset", 8'h00, {7'h00, seen});
      manual_push_reset_n = 1'b0;
      wait_rst(1'b1, 12, n);
      m.start();
      send("address in reset", 8'hA0, 1'b0);
      @(negedge i_clk);
      manual_push_reset_n = 1'b1;
      wait_rst(1'b0, PURST + 20, n);
      chk_rng("manual timeout", PURST, PURST + 12, n);
      repeat (4) @(negedge i_clk);
      send("byte without start", 8'hA0, 1'b0);
      m.stop();
      poll(1'b1);
   endtask

   task automatic t_pin();
      int n;
      @(negedge i_clk);
      pin_drv_n = 1'b0;
      repeat (4) @(negedge i_clk);
      pin_drv_n = 1'b1;
      wait_rst(1'b1, 12, n);
      wait_rst(1'b0, PURST + 20, n);
      chk_rng("pin timeout", PURST - 8, PURST + 8, n);
   endtask

   // Supply drop right after a write: the running programming still lands
   task automatic t_supply();
      int n;
      write_bytes(8'h60, 8'h77, 1, 1'b1);
      @(negedge i_clk);
      i_below_thr = 1'b1;
      wait_rst(1'b1, 6, n);
      repeat (50) @(negedge i_clk);
      chk("reset while low supply", 8'h01, {7'h00, o_reset});
      i_below_thr = 1'b0;
      wait_rst(1'b0, PURST + 20, n);
      chk_rng("supply timeout", PURST, PURST + 8, n);
      repeat (4) @(negedge i_clk);
      read_chk(8'h60, 1);
   endtask

   initial begin
      int n;
      repeat (4) @(negedge i_clk);
      i_rst = 1'b0;
      wait_rst(1'b0, PURST + 20, n);
      chk_rng("power-up timeout", PURST, PURST + 8, n);
      repeat (4) @(negedge i_clk);
      t_write_poll();
      t_type_code();
      t_protect();
      t_page();
      t_manual();
      t_pin();
      t_supply();
      final_report();
   end
endmodule
